//--- sample_port_pkg.sv
`default_nettype none

package sample_port_pkg;

    // ****************************************************************
    // widths and counts
    // ****************************************************************
    localparam int unsigned NUM_PORTS  = 3;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned TAG_W      = 3;
    localparam int unsigned BUF_DEPTH  = 2;
    localparam int unsigned PCLK_DIV   = 2;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [TAG_W-1:0]  TAG_RST  = 3'h0;

    // ****************************************************************
    // sender states, one-hot
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_REQ  = 2'b10
    } send_state_e;

endpackage : sample_port_pkg

`default_nettype wire

//--- sample_output_port.sv
`default_nettype none

module sample_output_port
    import sample_port_pkg::*;
(
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    // port clock mode and pin
    input  wire logic                       master_mode_i,
    input  wire logic                       port_clock_in_i,
    output logic                            port_clock_o,
    output logic                            port_clock_oe_o,
    // core side, one lane per port
    input  wire logic [NUM_PORTS-1:0]       word_valid_i,
    output logic      [NUM_PORTS-1:0]       word_ready_o,
    input  wire logic [NUM_PORTS*DATA_W-1:0] word_data_i,
    input  wire logic [NUM_PORTS*TAG_W-1:0] word_tag_i,
    input  wire logic [NUM_PORTS-1:0]       word_inphase_i,
    input  wire logic [NUM_PORTS-1:0]       word_gain_i,
    // port a
    output logic      [DATA_W-1:0]          port_a_sample_bus,
    output logic      [TAG_W-1:0]           port_a_channel_tag,
    output logic                            port_a_inphase_flag,
    output logic                            port_a_gain_flag,
    output logic                            port_a_request,
    input  wire logic                       port_a_acknowledge,
    // port b
    output logic      [DATA_W-1:0]          port_b_sample_bus,
    output logic      [TAG_W-1:0]           port_b_channel_tag,
    output logic                            port_b_inphase_flag,
    output logic                            port_b_gain_flag,
    output logic                            port_b_request,
    input  wire logic                       port_b_acknowledge,
    // port c
    output logic      [DATA_W-1:0]          port_c_sample_bus,
    output logic      [TAG_W-1:0]           port_c_channel_tag,
    output logic                            port_c_inphase_flag,
    output logic                            port_c_gain_flag,
    output logic                            port_c_request,
    input  wire logic                       port_c_acknowledge
);

    localparam int unsigned ENT_W = DATA_W + TAG_W + 2;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // buffer fill after one edge of pushes and pops; one sum feeds both
    // the count and the registered ready flag, so they cannot drift
    function automatic logic [1:0] fill_next(input logic [1:0] fill,
                                             input logic       add,
                                             input logic       take);
        return fill + 2'(add) - 2'(take);
    endfunction : fill_next

    // ****************************************************************
    // port clock
    // ****************************************************************
    // master: divided clk_i driven out; slave: pin sampled as a strobe
    logic port_clock_q;
    logic slave_clk_q;
    logic edge_tick;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_clock_q <= 1'b0;
        end else begin
            // held low in slave mode so the pin driver stays quiet
            port_clock_q <= master_mode_i ? ~port_clock_q : 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_clock_oe_o <= 1'b0;
        end else begin
            port_clock_oe_o <= master_mode_i;
        end
    end

    // last pin level, for the slave-mode rising edge detect
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slave_clk_q <= 1'b0;
        end else begin
            slave_clk_q <= port_clock_in_i;
        end
    end

    assign port_clock_o = port_clock_q;

    // a transfer edge is a rising port clock edge in either mode
    assign edge_tick = master_mode_i ? ~port_clock_q
                                     : (port_clock_in_i & ~slave_clk_q);

    // ****************************************************************
    // per-port buffer and handshake
    // ****************************************************************
    logic [NUM_PORTS*DATA_W-1:0] bus_q;
    logic [NUM_PORTS*TAG_W-1:0]  tag_q;
    logic [NUM_PORTS-1:0]        iq_q;
    logic [NUM_PORTS-1:0]        gain_q;
    logic [NUM_PORTS-1:0]        req_q;
    logic [NUM_PORTS-1:0]        ack_w;

    assign ack_w = {port_c_acknowledge, port_b_acknowledge,
                    port_a_acknowledge};

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        logic [ENT_W-1:0] mem_q [BUF_DEPTH];
        logic             wp_q;
        logic             rp_q;
        logic [1:0]       cnt_q;
        logic [1:0]       cnt_d;
        logic             push;
        logic             pop;
        logic             full;
        send_state_e      st_q;
        logic [ENT_W-1:0] head;

        assign full  = (cnt_q == 2'(BUF_DEPTH));
        assign push  = word_valid_i[p] & ~full;
        // load a new word only when idle on a port clock edge
        assign pop   = (st_q == ST_IDLE) & (cnt_q != 2'h0) & edge_tick;
        assign head  = mem_q[rp_q];
        assign cnt_d = fill_next(cnt_q, push, pop);

        // ************************************************************
        // word buffer
        // ************************************************************
        // no reset on storage: a slot is read only after it was written
        always_ff @(posedge clk_i) begin
            if (push) begin
                mem_q[wp_q] <= {word_data_i[p*DATA_W +: DATA_W],
                                word_tag_i[p*TAG_W +: TAG_W],
                                word_inphase_i[p], word_gain_i[p]};
            end
        end

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                wp_q <= 1'b0;
                rp_q <= 1'b0;
            end else begin
                if (push) begin
                    wp_q <= ~wp_q;
                end
                if (pop) begin
                    rp_q <= ~rp_q;
                end
            end
        end

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                cnt_q           <= 2'h0;
                word_ready_o[p] <= 1'b0;
            end else begin
                cnt_q           <= cnt_d;
                // registered ready: room left after this edge
                word_ready_o[p] <= cnt_d < 2'(BUF_DEPTH);
            end
        end

        // ************************************************************
        // sender handshake
        // ************************************************************

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                st_q                         <= ST_IDLE;
                req_q[p]                     <= 1'b0;
                bus_q[p*DATA_W +: DATA_W]    <= DATA_RST;
                tag_q[p*TAG_W +: TAG_W]      <= TAG_RST;
                iq_q[p]                      <= 1'b0;
                gain_q[p]                    <= 1'b0;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        if (pop) begin
                            {bus_q[p*DATA_W +: DATA_W],
                             tag_q[p*TAG_W +: TAG_W],
                             iq_q[p], gain_q[p]} <= head;
                            req_q[p] <= 1'b1;
                            st_q     <= ST_REQ;
                        end
                    end
                    ST_REQ: begin
                        // word held until ack seen on a port clock edge
                        if (edge_tick && ack_w[p]) begin
                            req_q[p] <= 1'b0;
                            st_q     <= ST_IDLE;
                        end
                    end
                    default: begin
                        st_q     <= ST_IDLE;
                        req_q[p] <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // pins
    // ****************************************************************
    assign port_a_sample_bus   = bus_q[0*DATA_W +: DATA_W];
    assign port_b_sample_bus   = bus_q[1*DATA_W +: DATA_W];
    assign port_c_sample_bus   = bus_q[2*DATA_W +: DATA_W];
    assign port_a_channel_tag  = tag_q[0*TAG_W +: TAG_W];
    assign port_b_channel_tag  = tag_q[1*TAG_W +: TAG_W];
    assign port_c_channel_tag  = tag_q[2*TAG_W +: TAG_W];
    assign port_a_inphase_flag = iq_q[0];
    assign port_b_inphase_flag = iq_q[1];
    assign port_c_inphase_flag = iq_q[2];
    assign port_a_gain_flag    = gain_q[0];
    assign port_b_gain_flag    = gain_q[1];
    assign port_c_gain_flag    = gain_q[2];
    assign port_a_request      = req_q[0];
    assign port_b_request      = req_q[1];
    assign port_c_request      = req_q[2];

endmodule : sample_output_port

`default_nettype wire

//--- sample_output_port_sva.sv
`default_nettype none
module sample_output_port_sva
    import sample_port_pkg::*;
(
    // clock, reset and port clock
    input wire logic              clk_i,
    input wire logic              rst_n_i,
    input wire logic              master_mode_i,
    input wire logic              port_clock_o,
    input wire logic              port_clock_oe_o,
    // port a
    input wire logic              port_a_request,
    input wire logic              port_a_acknowledge,
    input wire logic              port_a_inphase_flag,
    input wire logic              port_a_gain_flag,
    input wire logic [TAG_W-1:0]  port_a_channel_tag,
    input wire logic [DATA_W-1:0] port_a_sample_bus,
    // ports b and c
    input wire logic [DATA_W-1:0] port_b_sample_bus,
    input wire logic              port_b_request,
    input wire logic              port_b_acknowledge,
    input wire logic              port_c_request
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_A_HOLD: assert property (
        port_a_request && !port_a_acknowledge |=> port_a_request
        && $stable({port_a_sample_bus, port_a_channel_tag,
        port_a_inphase_flag, port_a_gain_flag})) else $error("a word moved");
    AST_B_HOLD: assert property (
        port_b_request && !port_b_acknowledge |=> port_b_request
        && $stable(port_b_sample_bus)) else $error("b word moved");
    AST_MCLK_TOGGLE: assert property (master_mode_i[*2] |=>
        port_clock_oe_o && port_clock_o != $past(port_clock_o))
        else $error("master port clock stuck");
    AST_SLAVE_QUIET: assert property (!master_mode_i[*2] |=>
        !port_clock_oe_o && !port_clock_o) else $error("slave pin driven");
    AST_REQ_RISE: assert property ($rose(port_a_request)
        && $past(master_mode_i) |-> !$past(port_clock_o))
        else $error("request off port clock edge");
    AST_REQ_FALL: assert property ($fell(port_a_request)
        |-> $past(port_a_acknowledge)) else $error("request fell unacked");
    AST_ACK_TAKEN: assert property (port_a_request
        && port_a_acknowledge && master_mode_i && !port_clock_o
        |=> !port_a_request) else $error("ack not taken");
    AST_RESET: assert property (disable iff (1'b0) !rst_n_i
        |-> !(port_a_request | port_b_request | port_c_request)
        && !port_clock_oe_o) else $error("outputs live in reset");
endmodule : sample_output_port_sva
`default_nettype wire

//--- port_receiver_model.sv
`default_nettype none
module port_receiver_model (
    // handshake with all three ports
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [2:0]  req_i,
    input  wire logic [62:0] word_i,
    input  wire logic [3:0]  dly_i,
    output logic      [2:0]  ack_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [20:0] got [3][$];
    logic [2:0]  req_q;
    logic [3:0]  wait_q [3];
    // ack lingers a cycle past the request, as a real receiver may
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_o <= 3'h0;
            req_q <= 3'h0;
            wait_q <= '{default: 4'h0};
        end else begin
            req_q <= req_i;
            for (int p = 0; p < 3; p++) begin
                wait_q[p] <= req_i[p] ?
                    wait_q[p] + 4'(wait_q[p] != dly_i) : 4'h0;
                ack_o[p] <= req_i[p] && wait_q[p] == dly_i;
                if (req_q[p] && !req_i[p])
                    got[p].push_back(word_i[21*p +: 21]);
            end
        end
    end
endmodule : port_receiver_model
`default_nettype wire

//--- tb_parallel_sample_output_port.sv
`default_nettype none
module tb_parallel_sample_output_port;
    timeunit 1ns;
    timeprecision 1ns;
    // reset starts high so its drop at time zero is a real edge
    logic clk_i = 1'b0, rst_n_i = 1'b1, mm = 1'b1, srun = 1'b0;
    logic [2:0] vld = 3'h0, iq = 3'h0, gn = 3'h0, sdiv = 3'h0;
    logic [47:0] dat = 48'h0;
    logic [8:0] tg = 9'h0;
    logic [3:0] dly = 4'h0;
    logic [15:0] n_cyc = 16'h0;
    int n_errors = 0, n_compared = 0;
    logic [20:0] exp_q [3][$];
    wire logic [62:0] pw;
    wire logic [2:0] rdy, req, ack;
    wire logic oe, pco;
    sample_output_port DUT (.clk_i, .rst_n_i, .master_mode_i(mm),
        .port_clock_in_i(sdiv[2]), .port_clock_o(pco), .port_clock_oe_o(oe),
        .word_valid_i(vld), .word_ready_o(rdy), .word_data_i(dat),
        .word_tag_i(tg), .word_inphase_i(iq), .word_gain_i(gn),
        .port_a_sample_bus(pw[15:0]), .port_a_channel_tag(pw[18:16]),
        .port_a_inphase_flag(pw[19]), .port_a_gain_flag(pw[20]),
        .port_a_request(req[0]), .port_a_acknowledge(ack[0]),
        .port_b_sample_bus(pw[36:21]), .port_b_channel_tag(pw[39:37]),
        .port_b_inphase_flag(pw[40]), .port_b_gain_flag(pw[41]),
        .port_b_request(req[1]), .port_b_acknowledge(ack[1]),
        .port_c_sample_bus(pw[57:42]), .port_c_channel_tag(pw[60:58]),
        .port_c_inphase_flag(pw[61]), .port_c_gain_flag(pw[62]),
        .port_c_request(req[2]), .port_c_acknowledge(ack[2]));
    port_receiver_model RX (.clk_i, .rst_n_i, .req_i(req), .word_i(pw),
        .dly_i(dly), .ack_o(ack));
    // ****
    // receiver-made port clock runs only in the slave test
    // ****
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) sdiv <= srun ? sdiv + 3'h1 : 3'h0;
    always @(posedge clk_i) begin
        n_cyc <= n_cyc + 16'h1;
        if (n_cyc == 16'h1770) begin
            n_errors++;
            tally_and_finish();
        end
    end
    function automatic logic [20:0] wd(int p, int k);
        return {2'(k), 3'(p + k), 16'(16'ha5c0 + 16 * p + k)};
    endfunction : wd
    task automatic chk(string what, logic [20:0] seen, logic [20:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic push(int p, logic [20:0] w);
        exp_q[p].push_back(w);
        @(posedge clk_i);
        vld[p] <= 1'b1;
        dat[16*p +: 16] <= w[15:0];
        tg[3*p +: 3] <= w[18:16];
        {gn[p], iq[p]} <= w[20:19];
        do @(negedge clk_i); while (rdy[p] !== 1'b1);
        @(posedge clk_i);
        vld[p] <= 1'b0;
    endtask : push
    task automatic cmp_all(string name);
        for (int p = 0; p < 3; p++) begin
            while (RX.got[p].size() < exp_q[p].size()) @(posedge clk_i);
            foreach (exp_q[p][i])
                chk(name, RX.got[p][i], exp_q[p][i]);
            RX.got[p].delete();
            exp_q[p].delete();
        end
        $display("%s test done", name);
    endtask : cmp_all
    task automatic t_master;
        fork
            for (int k = 0; k < 4; k++) push(0, wd(0, k));
            for (int k = 0; k < 4; k++) push(1, wd(1, k));
            for (int k = 0; k < 4; k++) push(2, wd(2, k));
        join
        chk("clock enable", 21'(oe), 21'h1);
        cmp_all("master");
    endtask : t_master
    task automatic t_stall;
        dly <= 4'hc;
        for (int k = 4; k < 7; k++) push(0, wd(0, k));
        @(negedge clk_i);
        chk("ready when full", 21'(rdy[0]), 21'h0);
        chk("held word", pw[20:0], wd(0, 4));
        chk("request", 21'(req[0]), 21'h1);
        cmp_all("stall");
    endtask : t_stall
    task automatic t_reset;
        // receiver stalls, so port c still holds its word at the reset
        dly <= 4'hf;
        push(2, wd(2, 12));
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk("request before reset", 21'(req[2]), 21'h1);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        @(negedge clk_i);
        chk("reset mid-run", {rdy, req, pw[56:42]}, 21'h0);
        exp_q[2].delete();
        @(posedge clk_i);
        dly <= 4'h0;
        rst_n_i <= 1'b1;
        push(2, wd(2, 13));
        cmp_all("reset");
    endtask : t_reset
    task automatic t_slave;
        dly <= 4'h0;
        @(posedge clk_i);
        mm <= 1'b0;
        srun <= 1'b1;
        push(1, wd(1, 8));
        push(1, wd(1, 9));
        cmp_all("slave");
        chk("slave pin", {19'h0, oe, pco}, 21'h0);
        @(posedge clk_i);
        srun <= 1'b0;
    endtask : t_slave
    task automatic tally_and_finish;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        rst_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk("reset outputs", {rdy, req, pw[14:0]}, 21'h0);
        rst_n_i <= 1'b1;
        t_master();
        t_stall();
        t_reset();
        t_slave();
        tally_and_finish();
    end
endmodule : tb_parallel_sample_output_port
bind sample_output_port sample_output_port_sva SVA (.clk_i, .rst_n_i,
    .master_mode_i, .port_clock_o, .port_clock_oe_o, .port_a_request,
    .port_a_acknowledge, .port_a_inphase_flag, .port_a_gain_flag,
    .port_a_channel_tag, .port_a_sample_bus, .port_b_sample_bus,
    .port_b_request, .port_b_acknowledge, .port_c_request);
`default_nettype wire
